// File: hw/ref_exc_config.sv
// reference and excitation configuration bank behind AXI4-Lite
// assumes one clock, synchronous active low reset, a 32-bit bus
// and a power_down level from the converter mode logic
//
// Overview of operation
// R1 - Bits 7:6 of the reference register pick no monitor, low monitor, low and high, or low with pull-together.
// R2 - Bit 5 of the reference register bypasses the positive reference buffer when one, enabled at reset.
// R3 - Bit 4 of the reference register bypasses the negative reference buffer when one and resets to one.
// R4 - Bits 3:2 of the reference register select pair zero, pair one or the internal reference, code three reserved.
// R5 - Bits 1:0 of the reference register keep the internal reference off, on until power down, or always on.
// R6 - Software should bypass both buffers whenever it selects the internal reference.
// R7 - Software must power the internal reference before it sets a nonzero excitation magnitude.
// R8 - Bit 7 of the excitation register enables the amplifier rail monitor, off at reset.
// R9 - Bit 6 of the excitation register closes the low side switch, which opens itself in power down.
// R10 - Bits 3:0 of the excitation register set both current sources to one value from off up to 1500 uA.
// R11 - The excitation register sits at index 6 and clears to zero on reset.
// R12 - The reference register sits at index 5 and resets with only the negative bypass bit set.
// R13 - Bits 5:4 of the excitation register ignore writes and read zero, and software writes them as zero.
//
// Our own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module ref_exc_config
   import ref_exc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // write address channel
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // write data channel
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // write response channel
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // read address channel
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // read data channel
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // converter mode
   input wire logic power_down,
   // reference controls
   output logic ref_low_threshold_monitor,
   output logic ref_high_threshold_monitor,
   output logic ref_pull_together_enable,
   output logic pos_ref_buffer_enable,
   output logic neg_ref_buffer_enable,
   output logic ref_sel_pair_zero,
   output logic ref_sel_pair_one,
   output logic ref_sel_internal,
   output logic internal_ref_on,
   // excitation controls
   output logic amp_rail_monitor_enable,
   output logic low_side_switch_closed,
   output logic [3:0] excitation_magnitude,
   output logic [10:0] excitation_current_ua
);

////////////////////////////////////////////////////////////////////////////////
   // storage and bus bookkeeping
   logic [7:0] ref_ctrl_reg;
   logic [7:0] exc_reg;
   logic order_warn_reg;
   logic order_warn_next;
   wr_state_t wr_state_reg;
   wr_state_t wr_state_next;
   rd_state_t rd_state_reg;
   logic aw_held_reg;
   logic aw_held_next;
   logic w_held_reg;
   logic w_held_next;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   logic aw_take;
   logic w_take;
   logic wr_fire;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic wr_lane0;
   logic ar_take;
   logic [31:0] rd_mux;
   logic rd_hit;
   logic [7:0] status;
   logic order_set;
   logic order_clr;

   assign awready = awready_reg;
   assign wready = wready_reg;
   assign bvalid = bvalid_reg;
   assign bresp = bresp_reg;
   assign arready = arready_reg;
   assign rvalid = rvalid_reg;
   assign rdata = rdata_reg;
   assign rresp = rresp_reg;

////////////////////////////////////////////////////////////////////////////////
   // write channel handshakes, address and data in either order
   assign aw_take = awvalid && awready_reg;
   assign w_take = wvalid && wready_reg;
   assign wr_addr = aw_take ? awaddr : aw_addr_reg;
   assign wr_data = w_take ? wdata : w_data_reg;
   assign wr_strb = w_take ? wstrb : w_strb_reg;
   assign wr_lane0 = wr_strb[0];

   // write sequencing
   always_comb begin
      aw_held_next = aw_held_reg || aw_take;
      w_held_next = w_held_reg || w_take;
      wr_state_next = wr_state_reg;
      wr_fire = 1'b0;
      case (wr_state_reg)
         WR_COLLECT: begin
            if (aw_held_next && w_held_next) begin
               wr_fire = 1'b1;
               aw_held_next = 1'b0;
               w_held_next = 1'b0;
               wr_state_next = WR_RESP;
            end
         end
         WR_RESP: begin
            if (bready) begin
               wr_state_next = WR_COLLECT;
            end
         end
         default: begin
            wr_state_next = WR_COLLECT;
         end
      endcase
   end

   // write state, held flags and ready lines
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= WR_COLLECT;
         aw_held_reg <= 1'b0;
         w_held_reg <= 1'b0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
      end else begin
         wr_state_reg <= wr_state_next;
         aw_held_reg <= aw_held_next;
         w_held_reg <= w_held_next;
         awready_reg <= (wr_state_next == WR_COLLECT) && !aw_held_next;
         wready_reg <= (wr_state_next == WR_COLLECT) && !w_held_next;
      end
   end

   // payload capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_addr_reg <= REF_CTRL_ADDR;
         w_data_reg <= {PAD_ZERO, EXC_RST};
         w_strb_reg <= ST_PAD;
      end else begin
         if (aw_take) begin
            aw_addr_reg <= awaddr;
         end
         if (w_take) begin
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
      end
   end

   // write response, error for unmapped addresses
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else begin
         if (wr_fire) begin
            bvalid_reg <= 1'b1;
            if (wr_addr == REF_CTRL_ADDR || wr_addr == EXC_ADDR || wr_addr == STAT_ADDR) begin
               bresp_reg <= RESP_OKAY;
            end else begin
               bresp_reg <= RESP_SLVERR;
            end
         end else if (bvalid_reg && bready) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // reference control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_ctrl_reg <= REF_CTRL_RST; // R12
      end else if (wr_fire && wr_lane0 && wr_addr == REF_CTRL_ADDR) begin
         ref_ctrl_reg <= wr_data[7:0]; // R12
      end
   end

   // excitation register, reserved bits never stored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         exc_reg <= EXC_RST; // R11
      end else if (wr_fire && wr_lane0 && wr_addr == EXC_ADDR) begin
         exc_reg <= wr_data[7:0] & EXC_WMASK; // R13
      end
   end

   // sticky flag for current requested while the reference power field is off or reserved
   assign order_set = (exc_reg[MAG_HI:MAG_LO] != MAG_OFF)
      && (ref_ctrl_reg[PWR_HI:PWR_LO] != PWR_ON_PD)
      && (ref_ctrl_reg[PWR_HI:PWR_LO] != PWR_ALWAYS); // R7
   assign order_clr = wr_fire && wr_lane0 && wr_addr == STAT_ADDR && wr_data[ST_ORDER];

   // set wins over a clear in the same cycle
   always_comb begin
      order_warn_next = order_warn_reg;
      if (order_clr) begin
         order_warn_next = 1'b0;
      end
      if (order_set) begin
         order_warn_next = 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         order_warn_reg <= 1'b0;
      end else begin
         order_warn_reg <= order_warn_next;
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // read side
   assign ar_take = arvalid && arready_reg;
   assign status = {ST_PAD, order_warn_reg, power_down, low_side_switch_closed, internal_ref_on};

   // read mux over the mapped words
   always_comb begin
      rd_mux = {PAD_ZERO, EXC_RST};
      rd_hit = 1'b1;
      case (araddr)
         REF_CTRL_ADDR: begin
            rd_mux = {PAD_ZERO, ref_ctrl_reg};
         end
         EXC_ADDR: begin
            rd_mux = {PAD_ZERO, exc_reg}; // R13
         end
         STAT_ADDR: begin
            rd_mux = {PAD_ZERO, status};
         end
         default: begin
            rd_hit = 1'b0;
         end
      endcase
   end

   // read data held until rready
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state_reg <= RD_IDLE;
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= {PAD_ZERO, EXC_RST};
         rresp_reg <= RESP_OKAY;
      end else begin
         case (rd_state_reg)
            RD_IDLE: begin
               arready_reg <= !ar_take;
               if (ar_take) begin
                  rd_state_reg <= RD_DATA;
                  rvalid_reg <= 1'b1;
                  rdata_reg <= rd_mux;
                  rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
               end
            end
            RD_DATA: begin
               if (rready) begin
                  rd_state_reg <= RD_IDLE;
                  rvalid_reg <= 1'b0;
                  arready_reg <= 1'b1;
               end
            end
            default: begin
               rd_state_reg <= RD_IDLE;
            end
         endcase
      end
   end

////////////////////////////////////////////////////////////////////////////////
   // field decode into registered controls
   ref_exc_decode u_decode (
      .aclk(aclk),
      .aresetn(aresetn),
      .ref_ctrl(ref_ctrl_reg),
      .exc_ctrl(exc_reg),
      .power_down(power_down),
      .ref_low_threshold_monitor(ref_low_threshold_monitor),
      .ref_high_threshold_monitor(ref_high_threshold_monitor),
      .ref_pull_together_enable(ref_pull_together_enable),
      .pos_ref_buffer_enable(pos_ref_buffer_enable),
      .neg_ref_buffer_enable(neg_ref_buffer_enable),
      .ref_sel_pair_zero(ref_sel_pair_zero),
      .ref_sel_pair_one(ref_sel_pair_one),
      .ref_sel_internal(ref_sel_internal),
      .internal_ref_on(internal_ref_on),
      .amp_rail_monitor_enable(amp_rail_monitor_enable),
      .low_side_switch_closed(low_side_switch_closed),
      .excitation_magnitude(excitation_magnitude),
      .excitation_current_ua(excitation_current_ua)
   );

////////////////////////////////////////////////////////////////////////////////
   // bank checks
   a_ref_reset_val: assert property (@(posedge aclk) // R12
      !aresetn |=> ref_ctrl_reg == REF_CTRL_RST)
      else $error("reference register reset value wrong");
   a_exc_reset_val: assert property (@(posedge aclk) // R11
      !aresetn |=> exc_reg == EXC_RST && excitation_current_ua == UA_NONE)
      else $error("excitation register reset value wrong");
   a_exc_reserved: assert property (@(posedge aclk) disable iff (!aresetn) // R13
      (ar_take && araddr == EXC_ADDR) |=> rdata_reg[5:4] == 2'h0 && rvalid_reg)
      else $error("reserved excitation bits read nonzero");
   a_exc_write: assert property (@(posedge aclk) disable iff (!aresetn) // R11
      (wr_fire && wr_lane0 && wr_addr == EXC_ADDR) |=> exc_reg == ($past(wr_data[7:0]) & EXC_WMASK)
      ##1 excitation_magnitude == $past(exc_reg[MAG_HI:MAG_LO]))
      else $error("excitation write not applied");
   a_rail_follow: assert property (@(posedge aclk) disable iff (!aresetn) // R8
      ##1 amp_rail_monitor_enable == $past(exc_reg[RAIL_BIT]))
      else $error("rail monitor enable wrong");
   a_order_flag: assert property (@(posedge aclk) disable iff (!aresetn) // R7
      order_set |=> order_warn_reg [*2])
      else $error("order flag not set");
   a_resp_after_both: assert property (@(posedge aclk) disable iff (!aresetn) // write handshake, our own choice
      $rose(bvalid_reg) |-> $past(wr_fire))
      else $error("write response without both channels");
endmodule
`default_nettype wire

// File: hw/ref_exc_decode.sv
// registered decode of the two configuration bytes into controls
// assumes the bytes come from the register bank in the same clock
`timescale 1ns/10ps
`default_nettype none
module ref_exc_decode
   import ref_exc_pkg::*;
(
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // configuration and mode
   input wire logic [7:0] ref_ctrl,
   input wire logic [7:0] exc_ctrl,
   input wire logic power_down,
   // reference controls
   output logic ref_low_threshold_monitor,
   output logic ref_high_threshold_monitor,
   output logic ref_pull_together_enable,
   output logic pos_ref_buffer_enable,
   output logic neg_ref_buffer_enable,
   output logic ref_sel_pair_zero,
   output logic ref_sel_pair_one,
   output logic ref_sel_internal,
   output logic internal_ref_on,
   // excitation controls
   output logic amp_rail_monitor_enable,
   output logic low_side_switch_closed,
   output logic [3:0] excitation_magnitude,
   output logic [10:0] excitation_current_ua
);
   logic [1:0] mon;
   logic [1:0] src;
   logic [1:0] pwr;
   logic [3:0] mag;

   assign mon = ref_ctrl[MON_HI:MON_LO];
   assign src = ref_ctrl[SRC_HI:SRC_LO];
   assign pwr = ref_ctrl[PWR_HI:PWR_LO];
   assign mag = exc_ctrl[MAG_HI:MAG_LO];

   // reference side controls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_low_threshold_monitor <= 1'b0;
         ref_high_threshold_monitor <= 1'b0;
         ref_pull_together_enable <= 1'b0;
         pos_ref_buffer_enable <= 1'b1;
         neg_ref_buffer_enable <= 1'b0;
         ref_sel_pair_zero <= 1'b1;
         ref_sel_pair_one <= 1'b0;
         ref_sel_internal <= 1'b0;
         internal_ref_on <= 1'b0;
      end else begin
         ref_low_threshold_monitor <= (mon != MON_OFF); // R1
         ref_high_threshold_monitor <= (mon == MON_BOTH); // R1
         ref_pull_together_enable <= (mon == MON_PULL); // R1
         pos_ref_buffer_enable <= !ref_ctrl[POS_BYP]; // R2
         neg_ref_buffer_enable <= !ref_ctrl[NEG_BYP]; // R3
         ref_sel_pair_zero <= (src == SRC_PAIR0); // R4
         ref_sel_pair_one <= (src == SRC_PAIR1); // R4
         ref_sel_internal <= (src == SRC_INT); // R4
         // reserved code leaves the reference off
         internal_ref_on <= (pwr == PWR_ALWAYS) || ((pwr == PWR_ON_PD) && !power_down); // R5
      end
   end

   // excitation side controls
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         amp_rail_monitor_enable <= 1'b0;
         low_side_switch_closed <= 1'b0;
         excitation_magnitude <= MAG_OFF;
         excitation_current_ua <= UA_NONE;
      end else begin
         amp_rail_monitor_enable <= exc_ctrl[RAIL_BIT]; // R8
         // switch forced open while powered down
         low_side_switch_closed <= exc_ctrl[SW_BIT] && !power_down; // R9
         excitation_magnitude <= mag; // R10
         excitation_current_ua <= (mag <= MAG_MAX) ? MAG_UA[mag] : UA_NONE; // R10
      end
   end

   // decode checks
   a_mon_decode: assert property (@(posedge aclk) disable iff (!aresetn) // R1
      ##1 ref_high_threshold_monitor == ($past(mon) == MON_BOTH)
      && ref_low_threshold_monitor == ($past(mon) != MON_OFF))
      else $error("reference monitor decode wrong");
   a_buf_bypass: assert property (@(posedge aclk) disable iff (!aresetn) // R3
      ##1 neg_ref_buffer_enable != $past(ref_ctrl[NEG_BYP])
      && pos_ref_buffer_enable != $past(ref_ctrl[POS_BYP]))
      else $error("reference buffer bypass wrong");
   a_src_onehot: assert property (@(posedge aclk) disable iff (!aresetn) // R4
      ##1 ref_sel_internal == ($past(src) == SRC_INT) && !(ref_sel_pair_zero && ref_sel_pair_one))
      else $error("reference source decode wrong");
   a_int_ref_pd: assert property (@(posedge aclk) disable iff (!aresetn) // R5
      (pwr == PWR_ON_PD && power_down) |=> !internal_ref_on)
      else $error("internal reference stays on in power down");
   a_switch_pd: assert property (@(posedge aclk) disable iff (!aresetn) // R9
      power_down |=> !low_side_switch_closed)
      else $error("low side switch closed in power down");
   a_mag_off: assert property (@(posedge aclk) disable iff (!aresetn) // R10
      (mag == MAG_OFF || mag > MAG_MAX) |=> excitation_current_ua == UA_NONE)
      else $error("excitation current not off");
endmodule
`default_nettype wire

// File: hw/ref_exc_pkg.sv
// constants for the reference and excitation configuration bank
// assumes a 32-bit AXI4-Lite slave with byte addresses of 8 bits
package ref_exc_pkg;
   // register indices, byte address is four times the index
   localparam logic [7:0] REF_CTRL_IDX = 8'h05;
   localparam logic [7:0] EXC_IDX = 8'h06;
   localparam logic [7:0] STAT_IDX = 8'h10;
   localparam logic [7:0] REF_CTRL_ADDR = REF_CTRL_IDX << 2;
   localparam logic [7:0] EXC_ADDR = EXC_IDX << 2;
   localparam logic [7:0] STAT_ADDR = STAT_IDX << 2;
   // reset values
   localparam logic [7:0] REF_CTRL_RST = 8'h10;
   localparam logic [7:0] EXC_RST = 8'h00;
   // writable bits of the excitation register, 5:4 stay zero
   localparam logic [7:0] EXC_WMASK = 8'hcf;
   // field positions
   localparam int MON_HI = 7;
   localparam int MON_LO = 6;
   localparam int POS_BYP = 5;
   localparam int NEG_BYP = 4;
   localparam int SRC_HI = 3;
   localparam int SRC_LO = 2;
   localparam int PWR_HI = 1;
   localparam int PWR_LO = 0;
   localparam int RAIL_BIT = 7;
   localparam int SW_BIT = 6;
   localparam int MAG_HI = 3;
   localparam int MAG_LO = 0;
   // status bits
   localparam int ST_REF_ON = 0;
   localparam int ST_SW = 1;
   localparam int ST_PD = 2;
   localparam int ST_ORDER = 3;
   // field codes
   localparam logic [1:0] MON_OFF = 2'h0;
   localparam logic [1:0] MON_LOW = 2'h1;
   localparam logic [1:0] MON_BOTH = 2'h2;
   localparam logic [1:0] MON_PULL = 2'h3;
   localparam logic [1:0] SRC_PAIR0 = 2'h0;
   localparam logic [1:0] SRC_PAIR1 = 2'h1;
   localparam logic [1:0] SRC_INT = 2'h2;
   localparam logic [1:0] PWR_OFF = 2'h0;
   localparam logic [1:0] PWR_ON_PD = 2'h1;
   localparam logic [1:0] PWR_ALWAYS = 2'h2;
   localparam logic [3:0] MAG_OFF = 4'h0;
   localparam logic [3:0] MAG_MAX = 4'h8;
   // current in microamps per magnitude code
   localparam logic [10:0] MAG_UA [0:8] = '{11'h000, 11'h00a, 11'h032, 11'h064,
      11'h0fa, 11'h1f4, 11'h2ee, 11'h3e8, 11'h5dc};
   localparam logic [10:0] UA_NONE = 11'h000;
   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [23:0] PAD_ZERO = 24'h000000;
   localparam logic [3:0] ST_PAD = 4'h0;
   // bus states
   typedef enum {WR_COLLECT, WR_RESP} wr_state_t;
   typedef enum {RD_IDLE, RD_DATA} rd_state_t;
endpackage

// File: tb/tb_top.sv
// self-checking bench for the reference and excitation register bank
// assumes the bank answers one AXI4-Lite write and one read at a time
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import ref_exc_pkg::*;
;
   ////////////////////////////////////////////////////////////////////////////////
   // bus and control signals, inputs other than aresetn start at known values
   logic aclk = 1'b0;
   logic aresetn;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [31:0] wdata = 32'h00000000;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic power_down = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic ref_low_threshold_monitor, ref_high_threshold_monitor, ref_pull_together_enable;
   logic pos_ref_buffer_enable, neg_ref_buffer_enable, ref_sel_pair_zero, ref_sel_pair_one;
   logic ref_sel_internal, internal_ref_on, amp_rail_monitor_enable, low_side_switch_closed;
   logic [3:0] excitation_magnitude;
   logic [10:0] excitation_current_ua;
   logic [33:0] exp_q[$];
   logic [31:0] seed = 32'h0000d49e;
   int err_count = 0;
   int total_checks = 0;
   // microamps per magnitude code, codes above eight give nothing
   logic [10:0] ua_tab [0:8] = '{11'h000, 11'h00a, 11'h032, 11'h064, 11'h0fa, 11'h1f4,
      11'h2ee, 11'h3e8, 11'h5dc};
   // decoded controls gathered for comparison
   wire [8:0] ref_seen = {ref_low_threshold_monitor, ref_high_threshold_monitor,
      ref_pull_together_enable, pos_ref_buffer_enable, neg_ref_buffer_enable,
      ref_sel_pair_zero, ref_sel_pair_one, ref_sel_internal, internal_ref_on};
   wire [16:0] exc_seen = {amp_rail_monitor_enable, low_side_switch_closed,
      excitation_magnitude, excitation_current_ua};

   // 50 MHz clock
   always #10 aclk = ~aclk;

   ref_exc_config u_dut (
      .aclk, .aresetn, .awaddr, .awprot, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arprot, .arvalid, .arready, .rdata,
      .rresp, .rvalid, .rready, .power_down, .ref_low_threshold_monitor,
      .ref_high_threshold_monitor, .ref_pull_together_enable, .pos_ref_buffer_enable,
      .neg_ref_buffer_enable, .ref_sel_pair_zero, .ref_sel_pair_one, .ref_sel_internal,
      .internal_ref_on, .amp_rail_monitor_enable, .low_side_switch_closed,
      .excitation_magnitude, .excitation_current_ua
   );

   ////////////////////////////////////////////////////////////////////////////////
   // helpers: random source, compare, verdict
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // oldest note, unknown when none is waiting so a stray answer fails
   function automatic logic [33:0] next_note();
      if (exp_q.size() == 0) return 'x;
      return exp_q.pop_front();
   endfunction

   task automatic check(input string what, input logic [33:0] seen, input logic [33:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic final_report();
      if (err_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // bus master tasks, wr and rd each note their expected answer first
   task automatic reset_dut();
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
      input logic [1:0] er);
      logic [31:0] r;
      r = xs();
      exp_q.push_back({er, 32'h00000000});
      awaddr <= a;
      wdata <= {r[23:0], d}; // upper bits are don't-care
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!(bvalid && bready));
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
      exp_q.push_back({er, 24'h000000, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!(rvalid && rready));
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   // decoded controls once the register change has landed
   task automatic dec(input logic [7:0] v, input logic [7:0] e);
      logic [8:0] rx;
      logic [16:0] ex;
      repeat (3) @(posedge aclk);
      rx = {v[7:6] != 2'h0, v[7:6] == 2'h2, v[7:6] == 2'h3, !v[5], !v[4], v[3:2] == 2'h0,
         v[3:2] == 2'h1, v[3:2] == 2'h2, v[1:0] == 2'h2 || (v[1:0] == 2'h1 && !power_down)};
      ex = {e[7], e[6] && !power_down, e[3:0], (e[3:0] <= 4'h8) ? ua_tab[e[3:0]] : 11'h000};
      check("ref_outputs", {25'h0, ref_seen}, {25'h0, rx});
      check("exc_outputs", {17'h0, exc_seen}, {17'h0, ex});
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // scoreboard: each bus answer against the oldest note
   always @(posedge aclk) begin
      if (bvalid && bready) check("write_resp", {bresp, 32'h00000000}, next_note());
      if (rvalid && rready) check("read_data", {rresp, rdata}, next_note());
   end

   // watchdog against a hung handshake
   initial begin
      repeat (20000) @(posedge aclk);
      err_count++;
      final_report();
   end

   // main sequence
   initial begin
      logic [7:0] v, e, s;
      logic [31:0] r;
      reset_dut();
      rd(REF_CTRL_ADDR, 8'h10, RESP_OKAY);
      rd(EXC_ADDR, 8'h00, RESP_OKAY);
      dec(8'h10, 8'h00);
      // every field code, then random settings with random power-down
      for (int i = 0; i < 20; i++) begin
         r = xs();
         v = (i < 4) ? {i[1:0], i[0], i[1], i[1:0], i[1:0]} : r[7:0];
         if (i >= 4) v[1:0] = r[8] ? PWR_ON_PD : PWR_ALWAYS;
         if (v[3:2] == SRC_INT) v[5:4] = 2'h3;
         e = {r[15:14], 2'h0, (i < 4) ? 4'h0 : 4'(i - 4)};
         power_down <= r[16];
         wr(REF_CTRL_ADDR, v, 4'hf, RESP_OKAY);
         wr(EXC_ADDR, e, 4'hf, RESP_OKAY);
         rd(REF_CTRL_ADDR, v, RESP_OKAY);
         rd(EXC_ADDR, e & 8'hcf, RESP_OKAY);
         dec(v, e);
         // status mirrors power-down, switch and reference state
         s = {5'h0, power_down, e[6] && !power_down,
            v[1:0] == PWR_ALWAYS || (v[1:0] == PWR_ON_PD && !power_down)};
         rd(STAT_ADDR, s, RESP_OKAY);
      end
      // refused and ignored accesses leave the registers alone
      wr(REF_CTRL_ADDR, 8'hff, 4'he, RESP_OKAY);
      wr(8'h1c, 8'h5a, 4'hf, RESP_SLVERR);
      wr(8'h15, 8'hff, 4'hf, RESP_SLVERR);
      rd(8'h15, 8'h00, RESP_SLVERR);
      rd(8'h00, 8'h00, RESP_SLVERR);
      rd(REF_CTRL_ADDR, v, RESP_OKAY);
      // reference dropped while current is set raises the sticky flag
      wr(REF_CTRL_ADDR, REF_CTRL_RST, 4'hf, RESP_OKAY);
      s = {5'h1, power_down, e[6] && !power_down, 1'b0};
      rd(STAT_ADDR, s, RESP_OKAY);
      // clear while the cause holds leaves it set
      wr(STAT_ADDR, 8'h08, 4'hf, RESP_OKAY);
      rd(STAT_ADDR, s, RESP_OKAY);
      wr(EXC_ADDR, 8'h00, 4'hf, RESP_OKAY);
      wr(STAT_ADDR, 8'h08, 4'hf, RESP_OKAY);
      rd(STAT_ADDR, {5'h0, power_down, 2'h0}, RESP_OKAY);
      // second reset in mid-run
      reset_dut();
      rd(REF_CTRL_ADDR, 8'h10, RESP_OKAY);
      rd(EXC_ADDR, 8'h00, RESP_OKAY);
      dec(8'h10, 8'h00);
      final_report();
   end
endmodule
`default_nettype wire
